//--- rtl/scl_ctrl.sv
/*
 * Low byte of the system control configuration register and the logic
 * that its bits steer: identification write protect, card parity report
 * onto the system error line, central DMA gate, clock-stop refusal and
 * the shared wake / ring-indicate output pin.
 * Assumes a configuration write/read strobe on the core clock and a
 * ring-indicate enable supplied by the card control register.
 */
`timescale 1ns/10ps
module scl_ctrl (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	// Configuration access
	input  wire logic       cfg_wr_i,
	input  wire logic       cfg_rd_i,
	input  wire logic [7:0] cfg_wdata_i,
	output logic      [7:0] cfg_rdata_o,
	// Identification register write gate
	input  wire logic       ident_wr_i,
	input  wire logic [2:0] ident_func_i,
	output logic            ident_wr_ok_o,
	// Parity error report
	input  wire logic       card_parity_err_i,
	output logic            serr_o,
	// Central DMA
	input  wire logic       dma_request_line_i,
	output logic            dma_grant_line_o,
	// Clock run
	input  wire logic       clk_stop_req_i,
	output logic            clk_stop_refuse_o,
	output logic            clk_stop_allow_o,
	// Shared wake / ring-indicate pin
	input  wire logic       pme_i,
	input  wire logic       ring_i,
	input  wire logic       ring_indicate_enable_i,
	output logic            wake_pin_o,
	output logic            wake_pin_oe_b_o,
	// Power mode
	output logic            low_power_enable_o
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] rdata;
		logic       ident_ok;
		logic       serr;
		logic       grant;
		logic       refuse;
		logic       allow;
		logic       pin;
		logic       pin_oe_b;
		logic       low_power;
	} scl_ctrl_s;

	scl_ctrl_s st_d;
	scl_ctrl_s st_q;

	scl_sync_if sync_if ();

	// Event, ring and clock-stop pins cross into the core clock before any logic sees them
	assign sync_if.raw[scl_pkg::SYN_PME]  = pme_i;
	assign sync_if.raw[scl_pkg::SYN_RING] = ring_i;
	assign sync_if.raw[scl_pkg::SYN_STOP] = clk_stop_req_i;

	scl_sync u_sync (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.sync_if    (sync_if)
	);

	// Masking reserved bits on write keeps their read value at zero
	function automatic logic [7:0] scl_mask(input logic [7:0] v);
		scl_mask = v & scl_pkg::CTRL_WMASK;
	endfunction

	logic pme_s;
	logic ring_s;
	logic stop_s;
	assign pme_s  = sync_if.synced[scl_pkg::SYN_PME];
	assign ring_s = sync_if.synced[scl_pkg::SYN_RING];
	assign stop_s = sync_if.synced[scl_pkg::SYN_STOP];

	// Next state for the byte and every registered output
	always_comb begin
		st_d = st_q;
		// Any function may write: the byte is shared state
		if (cfg_wr_i) begin
			st_d.ctrl = scl_mask(cfg_wdata_i);
		end
		if (cfg_rd_i) begin
			st_d.rdata = scl_mask(st_q.ctrl);
		end
		st_d.low_power = st_q.ctrl[scl_pkg::BIT_LOW_POWER];
		// Function 2 subsystem ID bypasses the protect bit
		st_d.ident_ok = ident_wr_i &&
			(!st_q.ctrl[scl_pkg::BIT_IDENT_WP] ||
			 ident_func_i == scl_pkg::FUNC_UNPROTECTED);
		st_d.serr = card_parity_err_i &&
			st_q.ctrl[scl_pkg::BIT_PARITY_REP];
		st_d.grant = dma_request_line_i &&
			st_q.ctrl[scl_pkg::BIT_DMA_EN];
		// Refusal only answers a pending stop request
		st_d.refuse = stop_s && st_q.ctrl[scl_pkg::BIT_CLK_HOLD];
		st_d.allow  = stop_s && !st_q.ctrl[scl_pkg::BIT_CLK_HOLD];
		// Shared pin: event, ring indicate, or released
		if (st_q.ctrl[scl_pkg::BIT_WAKE_SEL]) begin
			st_d.pin      = pme_s;
			st_d.pin_oe_b = 1'b0;
		end else if (ring_indicate_enable_i) begin
			st_d.pin      = ring_s;
			st_d.pin_oe_b = 1'b0;
		end else begin
			st_d.pin      = 1'b0;
			st_d.pin_oe_b = 1'b1;
		end
	end

	// State register
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q           <= '0;
			st_q.ctrl      <= scl_pkg::CTRL_RESET;
			st_q.low_power <= scl_pkg::CTRL_RESET[scl_pkg::BIT_LOW_POWER];
			st_q.pin_oe_b  <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flip-flops
	assign cfg_rdata_o        = st_q.rdata;
	assign ident_wr_ok_o      = st_q.ident_ok;
	assign serr_o             = st_q.serr;
	assign dma_grant_line_o   = st_q.grant;
	assign clk_stop_refuse_o  = st_q.refuse;
	assign clk_stop_allow_o   = st_q.allow;
	assign wake_pin_o         = st_q.pin;
	assign wake_pin_oe_b_o    = st_q.pin_oe_b;
	assign low_power_enable_o = st_q.low_power;

	// Checks
	a_rsvd_read_zero: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) cfg_rd_i |=>
		(!cfg_rdata_o[scl_pkg::BIT_RSVD7] && !cfg_rdata_o[scl_pkg::BIT_RSVD2]))
		else $error("reserved bit read nonzero");
	a_low_power_follow: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) cfg_wr_i ##1 !cfg_wr_i |=>
		low_power_enable_o == $past(cfg_wdata_i[scl_pkg::BIT_LOW_POWER], 2))
		else $error("low power output not following write");
	a_ident_protect: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		(ident_wr_i && st_q.ctrl[scl_pkg::BIT_IDENT_WP] &&
		 ident_func_i != scl_pkg::FUNC_UNPROTECTED) |=> !ident_wr_ok_o)
		else $error("protected identification write let through");
	a_func2_bypass: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		(ident_wr_i && ident_func_i == scl_pkg::FUNC_UNPROTECTED)
		|=> ident_wr_ok_o)
		else $error("function 2 subsystem write blocked");
	a_serr_cause: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) serr_o |->
		$past(card_parity_err_i) && $past(st_q.ctrl[scl_pkg::BIT_PARITY_REP]))
		else $error("system error without enabled parity cause");
	a_dma_gate: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		(dma_request_line_i && st_q.ctrl[scl_pkg::BIT_DMA_EN]) |=>
		dma_grant_line_o)
		else $error("enabled DMA request not granted");
	a_clk_refuse: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		(stop_s && st_q.ctrl[scl_pkg::BIT_CLK_HOLD]) |=>
		(clk_stop_refuse_o && !clk_stop_allow_o))
		else $error("clock stop not refused while held");
	a_clk_allow: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		(stop_s && !st_q.ctrl[scl_pkg::BIT_CLK_HOLD]) |=>
		(clk_stop_allow_o && !clk_stop_refuse_o))
		else $error("clock stop not allowed while free");
	a_pin_pme: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) st_q.ctrl[scl_pkg::BIT_WAKE_SEL] |=>
		(!wake_pin_oe_b_o && wake_pin_o == $past(pme_s)))
		else $error("event not on shared pin");
	a_pin_ring: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		(!st_q.ctrl[scl_pkg::BIT_WAKE_SEL] && ring_indicate_enable_i) |=>
		(!wake_pin_oe_b_o && wake_pin_o == $past(ring_s)))
		else $error("ring indicate not on shared pin");
	a_pin_release: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		(!st_q.ctrl[scl_pkg::BIT_WAKE_SEL] && !ring_indicate_enable_i) |=>
		wake_pin_oe_b_o)
		else $error("shared pin driven while released");
	a_rsvd_write: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) cfg_wr_i |=>
		(!st_q.ctrl[scl_pkg::BIT_RSVD7] && !st_q.ctrl[scl_pkg::BIT_RSVD2]))
		else $error("reserved bit stored");

	c_parity_report: cover property (@(posedge core_clk_i)
		disable iff (!rst_b_i) serr_o);
	c_clk_refused: cover property (@(posedge core_clk_i)
		disable iff (!rst_b_i) clk_stop_refuse_o);
	c_ring_driven: cover property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		!wake_pin_oe_b_o && !st_q.ctrl[scl_pkg::BIT_WAKE_SEL]);
	c_dma_granted: cover property (@(posedge core_clk_i)
		disable iff (!rst_b_i) dma_grant_line_o);
endmodule

//--- rtl/scl_pkg.sv
/*
 * Package for the low byte of the system control configuration register:
 * bit positions, reset values and the write mask.
 * Assumes the configuration path hands over one byte per access.
 */
package scl_pkg;

	// Bit positions inside the byte
	localparam int unsigned BIT_RSVD7      = 7;
	localparam int unsigned BIT_LOW_POWER  = 6;
	localparam int unsigned BIT_IDENT_WP   = 5;
	localparam int unsigned BIT_PARITY_REP = 4;
	localparam int unsigned BIT_DMA_EN     = 3;
	localparam int unsigned BIT_RSVD2      = 2;
	localparam int unsigned BIT_CLK_HOLD   = 1;
	localparam int unsigned BIT_WAKE_SEL   = 0;

	// Value after reset: low power and write protect set, rest clear
	localparam logic [7:0] CTRL_RESET = 8'h60;
	// Writable positions; reserved bits 7 and 2 stay zero
	localparam logic [7:0] CTRL_WMASK = 8'h7B;

	// Function number whose subsystem ID ignores the protect bit
	localparam logic [2:0] FUNC_UNPROTECTED = 3'h2;

	// Synchroniser depth for pin inputs
	localparam int unsigned SYNC_STAGES = 2;
	// Number of pin inputs brought through the synchroniser
	localparam int unsigned SYNC_WIDTH = 3;
	localparam int unsigned SYN_PME  = 0;
	localparam int unsigned SYN_RING = 1;
	localparam int unsigned SYN_STOP = 2;

endpackage

//--- rtl/scl_sync_if.sv
/*
 * Carrier between the control byte and its pin synchroniser.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/10ps
interface scl_sync_if;
	logic [scl_pkg::SYNC_WIDTH-1:0] raw;
	logic [scl_pkg::SYNC_WIDTH-1:0] synced;

	modport src (output raw, input synced);
	modport dst (input raw, output synced);
endinterface

//--- rtl/scl_sync.sv
/*
 * Two-stage synchroniser for the asynchronous pin inputs.
 * Assumes the raw inputs may change at any time relative to core_clk_i.
 */
`timescale 1ns/10ps
module scl_sync (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	// Pin side and synchronised side
	scl_sync_if.dst   sync_if
);
	typedef struct packed {
		logic [scl_pkg::SYNC_WIDTH-1:0] meta;
		logic [scl_pkg::SYNC_WIDTH-1:0] safe;
	} scl_sync_s;

	scl_sync_s st_d;
	scl_sync_s st_q;

	// First stage feeds only the second stage
	always_comb begin
		st_d      = st_q;
		st_d.meta = sync_if.raw;
		st_d.safe = st_q.meta;
	end

	// State register
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_if.synced = st_q.safe;
endmodule

//--- tb/scl_host_model.sv
/*
 * Far-side model: a DMA requester and a clock-stop requester.
 * Assumes the core clock and the active-low reset of the control byte.
 */
`timescale 1ns/10ps
module scl_host_model (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// Commands from the bench
	input  wire logic want_dma_i,
	input  wire logic want_stop_i,
	// Pins toward the control byte
	output logic      dma_req_o,
	input  wire logic dma_gnt_i,
	output logic      stop_req_o,
	output logic      got_gnt_o
);
	// Requests move only after an edge; a grant counts only while requesting
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dma_req_o  <= 1'b0;
			stop_req_o <= 1'b0;
			got_gnt_o  <= 1'b0;
		end else begin
			dma_req_o  <= want_dma_i;
			stop_req_o <= want_stop_i;
			got_gnt_o  <= dma_gnt_i & dma_req_o;
		end
	end
endmodule

//--- tb/scl_ctrl_tb.sv
/*
 * Self-checking bench for the system control low byte.
 * Assumes the pin synchroniser settles within six core clocks.
 */
`timescale 1ns/10ps
module scl_ctrl_tb;
	logic       clk, rst_b, cfg_wr, cfg_rd, id_wr, par_err, pme, ring;
	logic       ring_en, want_dma, want_stop, dma_req, stop_req, got_gnt;
	logic       ok, serr, gnt, refuse, allow, pin, oe_b, lowp;
	logic [7:0] wdata, rdata;
	logic [2:0] func;
	int         n_errors, num_checks, cyc;

	scl_ctrl DUT (.core_clk_i(clk), .rst_b_i(rst_b), .cfg_wr_i(cfg_wr),
		.cfg_rd_i(cfg_rd), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
		.ident_wr_i(id_wr), .ident_func_i(func), .ident_wr_ok_o(ok),
		.card_parity_err_i(par_err), .serr_o(serr),
		.dma_request_line_i(dma_req), .dma_grant_line_o(gnt),
		.clk_stop_req_i(stop_req), .clk_stop_refuse_o(refuse),
		.clk_stop_allow_o(allow), .pme_i(pme), .ring_i(ring),
		.ring_indicate_enable_i(ring_en), .wake_pin_o(pin),
		.wake_pin_oe_b_o(oe_b), .low_power_enable_o(lowp));
	scl_host_model u_host (.clk_i(clk), .rst_b_i(rst_b),
		.want_dma_i(want_dma), .want_stop_i(want_stop), .dma_req_o(dma_req),
		.dma_gnt_i(gnt), .stop_req_o(stop_req), .got_gnt_o(got_gnt));

	// Free-running core clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard, well above the roughly 115 cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			$display("FAIL t=%0t timeout", $time);
			wrap_up;
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Single-byte write, with no function number attached
	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		cfg_wr <= 1'b1;
		wdata  <= d;
		@(posedge clk);
		cfg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] exp);
		@(posedge clk);
		cfg_rd <= 1'b1;
		@(posedge clk);
		cfg_rd <= 1'b0;
		@(posedge clk);
		#1 chk(rdata, exp);
	endtask
	// Covers the three-cycle pin path with margin
	task automatic settle;
		repeat (6) @(posedge clk);
		#1;
	endtask

	task automatic t_reset;
		rd_chk(8'h60);
		chk(8'(lowp), 8'h01);
		chk(8'(oe_b), 8'h01);
		$display("test reset done");
	endtask
	task automatic t_reserved;
		wr(8'hFF);
		rd_chk(8'h7B);
		wr(8'h84);
		rd_chk(8'h00);
		settle;
		chk(8'(lowp), 8'h00);
		$display("test reserved done");
	endtask
	task automatic t_ident;
		wr(8'h20);
		@(posedge clk);
		id_wr <= 1'b1;
		settle;
		chk(8'(ok), 8'h00);
		@(posedge clk);
		func <= 3'h2;
		settle;
		chk(8'(ok), 8'h01);
		wr(8'h00);
		func <= 3'h0;
		settle;
		chk(8'(ok), 8'h01);
		@(posedge clk);
		id_wr <= 1'b0;
		$display("test ident done");
	endtask
	task automatic t_gates;
		@(posedge clk);
		par_err  <= 1'b1;
		want_dma <= 1'b1;
		want_stop <= 1'b1;
		settle;
		chk(8'(serr), 8'h00);
		chk(8'(gnt), 8'h00);
		chk(8'({refuse, allow}), 8'h01);
		wr(8'h1A);
		settle;
		chk(8'(serr), 8'h01);
		chk(8'(got_gnt), 8'h01);
		chk(8'({refuse, allow}), 8'h02);
		@(posedge clk);
		par_err  <= 1'b0;
		want_dma <= 1'b0;
		want_stop <= 1'b0;
		$display("test gates done");
	endtask
	task automatic t_wake;
		wr(8'h01);
		pme <= 1'b1;
		settle;
		chk(8'({oe_b, pin}), 8'h01);
		@(posedge clk);
		pme <= 1'b0;
		settle;
		chk(8'({oe_b, pin}), 8'h00);
		wr(8'h00);
		ring_en <= 1'b1;
		ring    <= 1'b1;
		settle;
		chk(8'({oe_b, pin}), 8'h01);
		// Select wins over ring enable: pin follows the idle event line
		wr(8'h01);
		settle;
		chk(8'({oe_b, pin}), 8'h00);
		wr(8'h00);
		ring_en <= 1'b0;
		settle;
		chk(8'(oe_b), 8'h01);
		$display("test wake done");
	endtask

	// Mid-run reset must bring the byte back to its reset value
	task automatic t_rerun;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk(8'h60);
		chk(8'(lowp), 8'h01);
		chk(8'(oe_b), 8'h01);
		$display("test rerun done");
	endtask

	// Main sequence, reset held for eight cycles
	initial begin
		{rst_b, cfg_wr, cfg_rd, id_wr, par_err, pme, ring} = '0;
		{ring_en, want_dma, want_stop, wdata, func} = '0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_reset;
		t_reserved;
		t_ident;
		t_gates;
		t_wake;
		t_rerun;
		wrap_up;
	end
endmodule
